// ---- design/tcps_pkg.sv ----
// constants for the timer clock select and prescaler front end
// Operation
// RULE1 - external count input passes a bus-clock synchronizer before its edges count
// RULE2 - external source runs at most a quarter of the bus clock frequency
// RULE3 - source field bits 5:4: 00 bus, 01 fixed clock, 10 falling, 11 rising pin
// RULE4 - source change while running keeps count and continues on new source
// RULE5 - prescale field bits 3:0 divides source by two to the field value
// RULE6 - prescale codes above 1000 divide by 256
// RULE7 - prescale change while running keeps count and continues at new rate
// RULE8 - reset clears prescale and source fields: bus clock, divide by one
// RULE9 - config bits 7:6 read zero and ignore writes
// RULE10 - counter runs and accepts ticks only while its stop bit is clear
// RULE11 - prescaler output is a one-cycle count-enable pulse per division period
// RULE12 - fixed clock and pin edges become one-cycle pulses, one advance per edge
package tcps_pkg;
	localparam logic [1:0] TIMER_CLOCK_CONFIG_OFS = 2'h0;
	localparam logic [1:0] TIMER_CTRL_OFS         = 2'h1;
	localparam logic [1:0] TIMER_STATUS_OFS       = 2'h2;
	localparam int         SRC_LSB                = 4;
	localparam int         PS_LSB                 = 0;
	localparam logic [1:0] SRC_RESET              = 2'h0;
	localparam logic [3:0] PS_RESET               = 4'h0;
	localparam logic [3:0] PS_MAX                 = 4'h8;
	localparam logic       STOP_RESET             = 1'h1;
	localparam int         PRESCALE_BITS          = 8;
	localparam logic [7:0] PRE_RESET              = 8'h00;
	typedef enum logic [3:0] {
		TCPS_SRC_BUS  = 4'h1,
		TCPS_SRC_FIX  = 4'h2,
		TCPS_SRC_FALL = 4'h4,
		TCPS_SRC_RISE = 4'h8
	} tcps_src_e;
endpackage

// ---- design/tcps_sync3.sv ----
// three-stage synchronizer with agreement filter for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module tcps_sync3 (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output var  logic level_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic nxt_level;

	// change counts only once stage two and three agree
	assign nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_ff    <= 1'b0;
			s2_ff    <= 1'b0;
			s3_ff    <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff    <= async_in;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign level_out = level_ff;
endmodule
`default_nettype wire

// ---- design/tcps_top.sv ----
// clock source select and power-of-two prescaler feeding the modulo timer counter
`timescale 1ns/1ps
`default_nettype none
module tcps_top #(
	parameter int PRE_W = tcps_pkg::PRESCALE_BITS
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic       fixed_freq_clock,
	input  wire logic       ext_count_input,
	output var  logic       count_enable,
	output var  logic       counter_active
);
	logic [1:0]       src_ff;
	logic [3:0]       ps_ff;
	logic             stop_ff;
	logic             active_ff;
	logic [7:0]       rdata_ff;
	logic [PRE_W-1:0] pre_ff;
	logic [PRE_W-1:0] nxt_pre;
	logic             fix_d_ff;
	logic             ext_d_ff;
	logic             tick_ff;
	logic             nxt_tick;
	logic             fix_lvl;
	logic             ext_lvl;
	logic             fix_rise;
	logic             ext_rise;
	logic             ext_fall;
	logic             src_pulse;
	logic             sel_cfg;
	logic             sel_ctl;
	logic             sel_sts;
	logic [3:0]       ps_eff;
	logic [PRE_W:0]   pre_ext;
	logic             div_done;
	logic [7:0]       nxt_rdata;
	tcps_pkg::tcps_src_e src_oh;

	// both slow inputs come from outside the bus clock domain
	tcps_sync3 u_sync_ext ( // RULE1
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.async_in  (ext_count_input),
		.level_out (ext_lvl)
	);
	tcps_sync3 u_sync_fix (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.async_in  (fixed_freq_clock),
		.level_out (fix_lvl)
	);

	// address decode
	assign sel_cfg = (reg_addr == tcps_pkg::TIMER_CLOCK_CONFIG_OFS);
	assign sel_ctl = (reg_addr == tcps_pkg::TIMER_CTRL_OFS);
	assign sel_sts = (reg_addr == tcps_pkg::TIMER_STATUS_OFS);

	// one-cycle edge pulses, so each edge advances the prescaler once
	assign fix_rise = fix_lvl & ~fix_d_ff; // RULE12
	assign ext_rise = ext_lvl & ~ext_d_ff; // RULE12
	assign ext_fall = ~ext_lvl & ext_d_ff; // RULE12

	// source decode into one-hot
	assign src_oh = (src_ff == 2'h1) ? tcps_pkg::TCPS_SRC_FIX : // RULE3
	                (src_ff == 2'h2) ? tcps_pkg::TCPS_SRC_FALL :
	                (src_ff == 2'h3) ? tcps_pkg::TCPS_SRC_RISE :
	                tcps_pkg::TCPS_SRC_BUS;

	always_comb begin
		case (src_oh)
			tcps_pkg::TCPS_SRC_FIX:  src_pulse = fix_rise;
			tcps_pkg::TCPS_SRC_FALL: src_pulse = ext_fall;
			tcps_pkg::TCPS_SRC_RISE: src_pulse = ext_rise;
			default:                 src_pulse = 1'b1;
		endcase
	end

	// codes above eight clamp to the largest division
	assign ps_eff = (ps_ff > tcps_pkg::PS_MAX) ? tcps_pkg::PS_MAX : ps_ff; // RULE6

	// divide by 2**ps: done when the low ps bits of the advanced count are zero
	assign pre_ext  = {1'b0, pre_ff} + {{PRE_W{1'b0}}, 1'b1};
	assign div_done = ((pre_ext & ((({{PRE_W{1'b0}}, 1'b1}) << ps_eff) - 1'b1))
	                   == '0); // RULE5
	// prescaler is not cleared on reconfiguration, the new rate just applies
	assign nxt_pre  = (src_pulse & ~stop_ff) ? pre_ext[PRE_W-1:0] : pre_ff; // RULE4 RULE7
	assign nxt_tick = src_pulse & ~stop_ff & div_done; // RULE10 RULE11

	// read mux; upper config bits always zero
	assign nxt_rdata = sel_cfg ? {2'h0, src_ff, ps_ff} : // RULE9
	                   sel_ctl ? {7'h00, stop_ff} :
	                   sel_sts ? {3'h0, ext_lvl, fix_lvl, src_oh == tcps_pkg::TCPS_SRC_BUS,
	                              tick_ff, ~stop_ff} :
	                   8'h00;

	// configuration registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			src_ff  <= tcps_pkg::SRC_RESET; // RULE8
			ps_ff   <= tcps_pkg::PS_RESET; // RULE8
			stop_ff <= tcps_pkg::STOP_RESET;
			active_ff <= ~tcps_pkg::STOP_RESET;
		end else if (reg_wr && sel_cfg) begin
			src_ff <= reg_wdata[tcps_pkg::SRC_LSB +: 2]; // RULE3
			ps_ff  <= reg_wdata[tcps_pkg::PS_LSB +: 4]; // RULE5
		end else if (reg_wr && sel_ctl) begin
			stop_ff <= reg_wdata[0]; // RULE10
			active_ff <= ~reg_wdata[0]; // RULE10
		end
	end

	// prescaler, edge history and outputs
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pre_ff   <= PRE_W'(tcps_pkg::PRE_RESET);
			fix_d_ff <= 1'b0;
			ext_d_ff <= 1'b0;
			tick_ff  <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			pre_ff   <= nxt_pre;
			fix_d_ff <= fix_lvl;
			ext_d_ff <= ext_lvl;
			tick_ff  <= nxt_tick;
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	assign count_enable   = tick_ff;
	assign counter_active = active_ff;
	assign reg_rdata      = rdata_ff;

	// a stopped counter receives no ticks from the cycle after the stop bit sets
	property p_stop_no_tick;
		@(posedge clk_sys) disable iff (sys_rst) stop_ff |=> !tick_ff;
	endproperty
	a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped"); // RULE10

	// tick is a single-cycle pulse when divided; a tick left from divide by one is exempt
	property p_tick_single;
		@(posedge clk_sys) disable iff (sys_rst)
			(tick_ff && ps_ff != 4'h0 && $past(ps_ff) != 4'h0) |=> !tick_ff;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle"); // RULE11

	// bus clock divide by one ticks every cycle while running
	property p_bus_div1;
		@(posedge clk_sys) disable iff (sys_rst)
			(src_ff == 2'h0 && ps_ff == 4'h0 && !stop_ff) |=> tick_ff;
	endproperty
	a_bus_div1: assert property (p_bus_div1) else $error("no tick at divide by one"); // RULE5

	// divide by two alternates on the bus clock
	sequence s_div2_steady;
		(src_ff == 2'h0 && ps_ff == 4'h1 && !stop_ff && !reg_wr) [*3];
	endsequence
	property p_bus_div2;
		@(posedge clk_sys) disable iff (sys_rst) s_div2_steady |-> tick_ff != $past(tick_ff);
	endproperty
	a_bus_div2: assert property (p_bus_div2) else $error("divide by two wrong"); // RULE5

	// clamped codes behave as divide by 256
	property p_clamp;
		@(posedge clk_sys) disable iff (sys_rst) (ps_ff > 4'h8) |-> ps_eff == 4'h8;
	endproperty
	a_clamp: assert property (p_clamp) else $error("prescale not clamped"); // RULE6

	// upper config bits read zero
	property p_hi_zero;
		@(posedge clk_sys) disable iff (sys_rst)
			(reg_rd && sel_cfg) |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("config bits 7:6 nonzero"); // RULE9

	// reconfiguring does not disturb the prescaler count
	property p_keep_count;
		@(posedge clk_sys) disable iff (sys_rst)
			(reg_wr && sel_cfg && !src_pulse) |=> pre_ff == $past(pre_ff);
	endproperty
	a_keep_count: assert property (p_keep_count) else $error("count disturbed"); // RULE7

	// a held pin level gives no tick on the rising-edge pin source
	property p_ext_edge;
		@(posedge clk_sys) disable iff (sys_rst)
			(src_ff == 2'h3 && ext_lvl == ext_d_ff) |=> !tick_ff;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("tick without pin edge"); // RULE12

	// reset leaves bus clock and divide by one
	property p_reset_vals;
		@(posedge clk_sys) sys_rst |=> (src_ff == 2'h0 && ps_ff == 4'h0);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values"); // RULE8

	// active output is the inverse of the stop bit
	property p_active_mirror;
		@(posedge clk_sys) disable iff (sys_rst)
			counter_active == !stop_ff;
	endproperty
	a_active_mirror: assert property (p_active_mirror) else $error("active wrong"); // RULE10

	// a stopped counter freezes the prescaler
	property p_stop_hold;
		@(posedge clk_sys) disable iff (sys_rst)
			stop_ff |=> pre_ff == $past(pre_ff);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("prescaler moved while stopped"); // RULE10

	// falling-edge source ignores a held pin level
	property p_fall_edge;
		@(posedge clk_sys) disable iff (sys_rst)
			(src_ff == 2'h2 && ext_lvl == ext_d_ff) |=> !tick_ff;
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("tick without falling edge"); // RULE12

	// fixed clock source ticks only on its edges
	property p_fix_edge;
		@(posedge clk_sys) disable iff (sys_rst)
			(src_ff == 2'h1 && fix_lvl == fix_d_ff) |=> !tick_ff;
	endproperty
	a_fix_edge: assert property (p_fix_edge) else $error("tick without fixed edge"); // RULE12

	// a config write keeps or advances the count, never clears it
	property p_src_keep;
		@(posedge clk_sys) disable iff (sys_rst)
			(reg_wr && sel_cfg) |=> (pre_ff == $past(pre_ff) || pre_ff == $past(pre_ff) + 1'b1);
	endproperty
	a_src_keep: assert property (p_src_keep) else $error("count cleared on config write"); // RULE4
endmodule
`default_nettype wire

// ---- verification/tcps_ext_src.sv ----
// model of the external source that drives the count input pin
`timescale 1ns/1ps
`default_nettype none
module tcps_ext_src #(
	parameter int HALF_NS = 32
) (
	input  wire logic run,
	output var  logic pin
);
	initial pin = 1'b0;
	// toggles only while run; it holds its level between bursts
	// the 64 ns period is eight bus clocks, twice the shortest legal period
	always begin
		#(HALF_NS);
		if (run) pin = ~pin;
	end
endmodule
`default_nettype wire

// ---- verification/test_timer_clock_select_prescaler.sv ----
// self-checking bench for the clock select and prescaler front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("FAIL %0t got %0h exp %0h", $time, a, e); end end
module test_timer_clock_select_prescaler;
	logic       clk_sys          = 1'b0;
	logic       sys_rst          = 1'b1;
	logic       reg_wr           = 1'b0;
	logic       reg_rd           = 1'b0;
	logic [1:0] reg_addr         = 2'h0;
	logic [7:0] reg_wdata        = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] rd_val;
	logic       fixed_freq_clock = 1'b0;
	logic       src_run          = 1'b0;
	logic       ext_count_input;
	logic       count_enable;
	logic       counter_active;
	logic [7:0] cfg[4]           = '{8'h30, 8'h20, 8'h31, 8'h10};
	int         exp_n[4]         = '{64, 64, 32, 51};
	int         bad_count        = 0;
	int         checks_done      = 0;
	int         n;

	// bus clock and a fixed clock of ten bus periods, edges on falling clk
	always #4 clk_sys = ~clk_sys;
	always #40 fixed_freq_clock = ~fixed_freq_clock;

	tcps_top #(.PRE_W(8)) uut (
		.clk_sys          (clk_sys),
		.sys_rst          (sys_rst),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.fixed_freq_clock (fixed_freq_clock),
		.ext_count_input  (ext_count_input),
		.count_enable     (count_enable),
		.counter_active   (counter_active)
	);

	tcps_ext_src #(.HALF_NS(32)) src (
		.run (src_run),
		.pin (ext_count_input)
	);

	// one-cycle strobes; the slave never stalls
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// counts tick pulses over a fixed window of bus cycles
	task automatic ticks(input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(posedge clk_sys);
			#1;
			if (count_enable === 1'b1) cnt++;
		end
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog so a stuck run still reaches the verdict
	initial begin
		#400000;
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(2'h0); `CHK(rd_val, 8'h00)
		rd(2'h1); `CHK(rd_val, 8'h01)
		rd(2'h2); `CHK(rd_val & 8'h07, 8'h04)
		`CHK(counter_active, 1'b0)
		ticks(64, n); `CHK(n, 0)
		wr(2'h0, 8'hff); rd(2'h0); `CHK(rd_val, 8'h3f)
		rd(2'h3); `CHK(rd_val, 8'h00)
		wr(2'h1, 8'h00);
		// all sixteen prescale codes on the bus source, changed while running
		for (int p = 0; p < 16; p++) begin
			wr(2'h0, p[7:0]);
			ticks(8, n);
			ticks(512, n); `CHK(n, 512 >> ((p > 8) ? 8 : p))
		end
		`CHK(counter_active, 1'b1)
		// pin and fixed sources; async phase allows one tick of slack
		src_run = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(2'h0, cfg[i]);
			ticks(16, n);
			ticks(512, n); `CHK(n >= exp_n[i] - 1 && n <= exp_n[i] + 1, 1'b1)
		end
		src_run = 1'b0;
		wr(2'h0, 8'h00);
		wr(2'h1, 8'h01);
		ticks(4, n);
		ticks(64, n); `CHK(n, 0)
		`CHK(counter_active, 1'b0)
		// second reset in mid-run clears the fields again
		wr(2'h0, 8'h25);
		wr(2'h1, 8'h00);
		#1;
		`CHK(counter_active, 1'b1)
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(2'h0); `CHK(rd_val, 8'h00)
		`CHK(counter_active, 1'b0)
		finish_test();
	end
endmodule
`default_nettype wire
